// ---- rtl/cpm_clock_path_cfg.sv ----
// clock path mode configuration: shadow, commit, calibration start, nonvolatile restore
`timescale 1ns/10ps
// Summary of operation
// - mode code 00 runs the pll normally, 01 holds it in asynchronous power-down
// - source bit 1 routes internal vco to distribution, 0 the external clock input
// - bypass bit 0 uses the vco divider, 1 bypasses it
// - reset gives pll power-down, divider used, code zero, external clock selected
// - calibration starts when a committed update takes the calibration bit from 0 to 1
// - pfd polarity bit 0 positive, 1 negative
// - default path passes external input up to 2400 MHz through the vco divider
// - pll with external vco: internal vco off, external signal feeds prescaler
// - configuration can be saved to nonvolatile store and is restored after each chip reset; power-on clears the valid flag of the saved word
// - reference inputs are disabled by default until enabled
module cpm_clock_path_cfg #(
  parameter int NV_DEPTH = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic nv_por_n,
  input wire logic clk_en,
  input wire logic shadow_wr,
  input wire logic [cpm_pkg::MASK_W-1:0] shadow_mask,
  input wire logic [cpm_pkg::MODE_W-1:0] pll_mode_in,
  input wire logic pfd_neg_in,
  input wire logic src_vco_in,
  input wire logic div_bypass_in,
  input wire logic [cpm_pkg::DIV_W-1:0] vco_div_in,
  input wire logic [cpm_pkg::REF_W-1:0] ref_en_in,
  input wire logic cal_wr,
  input wire logic cal_in,
  input wire logic update,
  input wire logic nv_save,
  output logic [cpm_pkg::MODE_W-1:0] pll_mode,
  output logic pll_on,
  output logic pfd_neg,
  output logic src_vco,
  output logic div_bypass,
  output logic [cpm_pkg::DIV_W-1:0] vco_div_code,
  output logic [2:0] div_ratio,
  output logic [cpm_pkg::REF_W-1:0] ref_en,
  output logic int_vco_on,
  output logic ext_to_prescaler,
  output logic cal_active,
  output logic cal_start,
  output logic ready
);
  import cpm_pkg::*;

  // refuse a store depth the logic cannot serve
  if (NV_DEPTH < 1) begin : g_bad_depth
    $error("cpm_clock_path_cfg: NV_DEPTH must be at least 1");
  end

  cpm_state_e state;
  cpm_state_e next_state;
  logic [CFG_W-1:0] shadow_cfg;
  logic shadow_cal;
  logic [CFG_W-1:0] active_cfg;
  logic [CFG_W-1:0] nv_rd_data;
  logic nv_rd_valid;

  // shadow write: per-field mask widened to a bit mask
  wire [CFG_W-1:0] wr_data = {ref_en_in, vco_div_in, div_bypass_in, src_vco_in, pfd_neg_in, pll_mode_in};
  wire [CFG_W-1:0] wr_bits = {{REF_W{shadow_mask[MSK_REF]}}, {DIV_W{shadow_mask[MSK_DIV]}},
                              shadow_mask[MSK_BYP], shadow_mask[MSK_SRC], shadow_mask[MSK_PFD],
                              {MODE_W{shadow_mask[MSK_MODE]}}};
  wire [CFG_W-1:0] next_shadow = shadow_wr ? ((shadow_cfg & ~wr_bits) | (wr_data & wr_bits)) : shadow_cfg;

  // commit and restore selection
  wire running = (state == CPM_ST_RUN);
  wire commit = running && update;
  wire restore = (state == CPM_ST_WAIT) && nv_rd_valid;
  wire [CFG_W-1:0] next_active = restore ? nv_rd_data : (commit ? shadow_cfg : active_cfg);
  wire next_cal = commit ? shadow_cal : cal_active;
  wire cal_edge = commit && shadow_cal && !cal_active;

  // decoded path controls from the next configuration
  wire [MODE_W-1:0] nx_mode = next_active[CFG_MODE_LSB +: MODE_W];
  wire nx_pll_on = (nx_mode == MODE_NORMAL);
  wire nx_src = next_active[CFG_SRC];
  wire nx_byp = next_active[CFG_BYP];
  wire [DIV_W-1:0] nx_div = next_active[CFG_DIV_LSB +: DIV_W];
  wire nx_int_vco = nx_pll_on && nx_src;
  wire nx_ext_pre = nx_pll_on && !nx_src;
  wire [2:0] nx_ratio = nx_byp ? RATIO_BYPASS : ratio_of(nx_div);

  // code 000 divides by 2, codes up to 100 reach 6, the rest give 1
  function automatic logic [2:0] ratio_of(input logic [DIV_W-1:0] code);
    logic [2:0] r;
    r = RATIO_BYPASS;
    if (code <= 3'h4) begin
      r = 3'(code + RATIO_CODE0);
    end
    return r;
  endfunction

  // startup sequencer: read the store once, then run
  always_comb begin
    next_state = state;
    case (state)
      CPM_ST_LOAD: next_state = CPM_ST_WAIT;
      CPM_ST_WAIT: next_state = CPM_ST_RUN;
      CPM_ST_RUN: next_state = CPM_ST_RUN;
      default: next_state = CPM_ST_LOAD;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CPM_ST_LOAD;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // shadow stage; a restore also seeds the shadow so the next commit keeps it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_cfg <= RST_CFG;
      shadow_cal <= RST_CAL;
    end else if (clk_en) begin
      shadow_cfg <= restore ? nv_rd_data : next_shadow;
      if (cal_wr) begin
        shadow_cal <= cal_in;
      end
    end
  end

  // active configuration and registered outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_cfg <= RST_CFG;
      cal_active <= RST_CAL;
      cal_start <= 1'b0;
      pll_on <= 1'b0;
      int_vco_on <= 1'b0;
      ext_to_prescaler <= 1'b0;
      div_ratio <= RATIO_CODE0;
      ready <= 1'b0;
    end else if (clk_en) begin
      active_cfg <= next_active;
      cal_active <= next_cal;
      cal_start <= cal_edge;
      pll_on <= nx_pll_on;
      int_vco_on <= nx_int_vco;
      ext_to_prescaler <= nx_ext_pre;
      div_ratio <= nx_ratio;
      ready <= (next_state == CPM_ST_RUN);
    end
  end

  // field views of the active word
  assign pll_mode = active_cfg[CFG_MODE_LSB +: MODE_W];
  assign pfd_neg = active_cfg[CFG_PFD];
  assign src_vco = active_cfg[CFG_SRC];
  assign div_bypass = active_cfg[CFG_BYP];
  assign vco_div_code = active_cfg[CFG_DIV_LSB +: DIV_W];
  assign ref_en = active_cfg[CFG_REF_LSB +: REF_W];

  // save takes the committed configuration; the store is read once while loading
  wire nv_wr = nv_save && running;
  wire nv_rd = (state == CPM_ST_LOAD);

  cpm_nv_store #(
    .W(CFG_W),
    .DEPTH(NV_DEPTH)
  ) u_nv (
    .mclk(mclk),
    .por_n(nv_por_n),
    .clk_en(clk_en),
    .wr_en(nv_wr),
    .wr_data(active_cfg),
    .rd_en(nv_rd),
    .rd_data(nv_rd_data),
    .rd_valid(nv_rd_valid)
  );

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_reset_defaults: assert property (!running |-> (pll_mode == RST_MODE && !src_vco && !div_bypass
    && vco_div_code == RST_DIV && ref_en == RST_REF_EN && !pll_on)) else $error("defaults not held");
  chk_update_commit: assert property (clk_en && commit |=> active_cfg == $past(shadow_cfg))
    else $error("update did not commit shadow");
  chk_shadow_hold: assert property (clk_en && running && !update |=> $stable(active_cfg))
    else $error("active changed without update");
  chk_cal_begin: assert property (clk_en && cal_edge |=> cal_start && cal_active)
    else $error("calibration did not start");
  chk_cal_rearm: assert property (clk_en && commit && cal_active |=> !cal_start)
    else $error("calibration restarted without clear");
  chk_pll_mode_on: assert property (pll_on == (pll_mode == MODE_NORMAL))
    else $error("pll on disagrees with mode");
  chk_source_route: assert property ((int_vco_on |-> src_vco && pll_on) and
    (ext_to_prescaler |-> !src_vco && pll_on)) else $error("source routing wrong");
  chk_div_ratio: assert property ((div_bypass |-> div_ratio == RATIO_BYPASS) and
    (!div_bypass && vco_div_code == 3'h0 |-> div_ratio == RATIO_CODE0)) else $error("ratio wrong");
  chk_nv_restore: assert property (clk_en && restore |=> active_cfg == $past(nv_rd_data))
    else $error("restore did not load");
  chk_restore_ready: assert property (clk_en && restore |=> ready)
    else $error("not ready after restore");
  chk_cal_single: assert property (clk_en && cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");

  // clock enable and early-update guards
  chk_enable_freeze: assert property (!clk_en |=> $stable(active_cfg) && $stable(shadow_cfg))
    else $error("configuration moved while clock enable low");
  chk_refuse_early: assert property (clk_en && !running && !restore |=> $stable(active_cfg) && !cal_start)
    else $error("update taken before ready");

  // covers for the main scenarios
  cov_commit_vco: cover property (commit ##1 int_vco_on && !div_bypass);
  cov_cal_start: cover property (cal_start);
  cov_restore: cover property (restore);
  cov_bypass_ext: cover property (div_bypass && ext_to_prescaler);
  cov_mode_other: cover property (commit ##1 !pll_on && pll_mode != RST_MODE);
endmodule

// ---- rtl/cpm_nv_store.sv ----
// nonvolatile configuration store with registered read data
`timescale 1ns/10ps
module cpm_nv_store #(
  parameter int W = 11,
  parameter int DEPTH = 1
) (
  input wire logic mclk,
  input wire logic por_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic rd_valid
);
  logic [W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid;

  // refuse sizes the store cannot hold
  if (W < 1 || DEPTH < 1) begin : g_bad_size
    $error("cpm_nv_store: W and DEPTH must be at least 1");
  end

  // contents survive the chip reset; only power-on clears the valid flags
  always_ff @(posedge mclk) begin
    if (clk_en && wr_en) begin
      mem[0] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      valid <= '0;
    end else if (clk_en && wr_en) begin
      valid[0] <= 1'b1;
    end
  end

  // registered read port
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else if (clk_en && rd_en) begin
      rd_data <= mem[0];
      rd_valid <= valid[0];
    end
  end
endmodule

// ---- rtl/cpm_pkg.sv ----
// constants and types shared by the clock path mode configuration block
package cpm_pkg;
  // pll mode field codes
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ASYNC_PD = 2'h1;
  // field widths
  localparam int DIV_W = 3;
  localparam int REF_W = 3;
  localparam int MASK_W = 6;
  // packed configuration word layout
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PFD = 2;
  localparam int CFG_SRC = 3;
  localparam int CFG_BYP = 4;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_REF_LSB = 8;
  localparam int CFG_W = 11;
  // field-enable mask bit positions
  localparam int MSK_MODE = 0;
  localparam int MSK_PFD = 1;
  localparam int MSK_SRC = 2;
  localparam int MSK_BYP = 3;
  localparam int MSK_DIV = 4;
  localparam int MSK_REF = 5;
  // values after reset
  localparam logic [1:0] RST_MODE = MODE_ASYNC_PD;
  localparam logic RST_PFD = 1'b0;
  localparam logic RST_SRC = 1'b0;
  localparam logic RST_BYP = 1'b0;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [2:0] RST_REF_EN = 3'h0;
  localparam logic RST_CAL = 1'b0;
  localparam logic [CFG_W-1:0] RST_CFG = {RST_REF_EN, RST_DIV, RST_BYP, RST_SRC, RST_PFD, RST_MODE};
  // effective divide ratios
  localparam logic [2:0] RATIO_BYPASS = 3'h1;
  localparam logic [2:0] RATIO_CODE0 = 3'h2;
  // frequency limits of the distribution path, in MHz
  localparam int MAX_CHAN_MHZ = 1600;
  localparam int MAX_EXT_MHZ = 2400;
  // startup sequencer
  typedef enum logic [1:0] {
    CPM_ST_LOAD = 2'b00,
    CPM_ST_WAIT = 2'b01,
    CPM_ST_RUN = 2'b10
  } cpm_state_e;
endpackage

// ---- sim/cpm_clock_path_cfg_tb.sv ----
// testbench for the clock path mode configuration block
`timescale 1ns/10ps
module cpm_clock_path_cfg_tb;
  import cpm_pkg::*;
  logic mclk, reset_n, nv_por_n, clk_en, shadow_wr, pfd_neg_in, src_vco_in, div_bypass_in;
  logic cal_wr, cal_in, update, nv_save;
  logic [5:0] shadow_mask;
  logic [1:0] pll_mode_in, pll_mode;
  logic [2:0] vco_div_in, ref_en_in, vco_div_code, div_ratio, ref_en;
  logic pll_on, pfd_neg, src_vco, div_bypass, int_vco_on, ext_to_prescaler, cal_active, cal_start, ready;
  int chan_mhz, fails, samples_checked;
  cpm_clock_path_cfg #(.NV_DEPTH(1)) i_dut (.mclk(mclk), .reset_n(reset_n), .nv_por_n(nv_por_n),
    .clk_en(clk_en), .shadow_wr(shadow_wr), .shadow_mask(shadow_mask), .pll_mode_in(pll_mode_in),
    .pfd_neg_in(pfd_neg_in), .src_vco_in(src_vco_in), .div_bypass_in(div_bypass_in),
    .vco_div_in(vco_div_in), .ref_en_in(ref_en_in), .cal_wr(cal_wr), .cal_in(cal_in), .update(update),
    .nv_save(nv_save), .pll_mode(pll_mode), .pll_on(pll_on), .pfd_neg(pfd_neg), .src_vco(src_vco),
    .div_bypass(div_bypass), .vco_div_code(vco_div_code), .div_ratio(div_ratio), .ref_en(ref_en),
    .int_vco_on(int_vco_on), .ext_to_prescaler(ext_to_prescaler), .cal_active(cal_active),
    .cal_start(cal_start), .ready(ready));
  cpm_src_model i_src (.src_vco(src_vco), .div_ratio(div_ratio), .chan_mhz(chan_mhz));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // compares every configuration output with values worked out here
  task automatic check_cfg(input logic [1:0] m, input logic p, s, b, input logic [2:0] d, r);
    logic [2:0] q;
    q = b ? 3'h1 : ((d <= 3'h4) ? d + 3'h2 : 3'h1);
    check({pll_mode, pll_on, pfd_neg, src_vco, div_bypass, vco_div_code, div_ratio, ref_en, int_vco_on,
      ext_to_prescaler}, {m, m == 2'h0, p, s, b, d, q, r, m == 2'h0 && s, m == 2'h0 && !s});
  endtask
  // shadow write, one enabled cycle
  task automatic cfg(input logic [5:0] k, input logic [1:0] m, input logic p, s, b, input logic [2:0] d, r);
    shadow_mask = k;
    pll_mode_in = m;
    pfd_neg_in = p;
    src_vco_in = s;
    div_bypass_in = b;
    vco_div_in = d;
    ref_en_in = r;
    shadow_wr = 1'b1;
    @(negedge mclk) shadow_wr = 1'b0;
  endtask
  task automatic commit;
    update = 1'b1;
    @(negedge mclk) update = 1'b0;
  endtask
  task automatic cal_set(input logic v);
    cal_in = v;
    cal_wr = 1'b1;
    @(negedge mclk) cal_wr = 1'b0;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    if (ready !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    give_verdict();
  end
  // main sequence
  initial begin
    {reset_n, nv_por_n, shadow_wr, cal_wr, cal_in, update, nv_save} = 7'h00;
    {shadow_mask, pll_mode_in, pfd_neg_in, src_vco_in, div_bypass_in, vco_div_in, ref_en_in} = 17'h0;
    clk_en = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(negedge mclk);
    check_cfg(2'h1, 0, 0, 0, 3'h0, 3'h0);
    check({cal_active, cal_start, ready}, 24'h0);
    check(chan_mhz <= MAX_CHAN_MHZ, 24'h1);
    reset_n = 1'b1;
    nv_por_n = 1'b1;
    // an update before ready is ignored
    cfg(6'h3F, 2'h0, 1, 1, 0, 3'h3, 3'h5);
    commit();
    check_cfg(2'h1, 0, 0, 0, 3'h0, 3'h0);
    wait_ready();
    cfg(6'h3F, 2'h0, 1, 1, 0, 3'h3, 3'h5);
    check_cfg(2'h1, 0, 0, 0, 3'h0, 3'h0);
    commit();
    check_cfg(2'h0, 1, 1, 0, 3'h3, 3'h5);
    cfg(6'h3F, 2'h0, 0, 0, 0, 3'h0, 3'h1);
    commit();
    check_cfg(2'h0, 0, 0, 0, 3'h0, 3'h1);
    for (int i = 0; i < 16; i++) begin
      cfg(6'h3F, 2'h0, 0, 0, i[3], i[2:0], 3'h1);
      commit();
      check_cfg(2'h0, 0, 0, i[3], i[2:0], 3'h1);
    end
    // only the polarity field is enabled
    cfg(6'h01 << MSK_PFD, 2'h1, 1, 1, 0, 3'h2, 3'h0);
    commit();
    check_cfg(2'h0, 1, 0, 1, 3'h7, 3'h1);
    // an update while the clock enable is low is not taken; mode 11 is not normal
    cfg(6'h3F, 2'h3, 0, 0, 0, 3'h1, 3'h7);
    clk_en = 1'b0;
    commit();
    check_cfg(2'h0, 1, 0, 1, 3'h7, 3'h1);
    clk_en = 1'b1;
    @(negedge mclk);
    commit();
    check_cfg(2'h3, 0, 0, 0, 3'h1, 3'h7);
    // calibration start, repeat refused, restart after clearing
    cal_set(1'b1);
    commit();
    check({cal_active, cal_start}, 24'h3);
    @(negedge mclk);
    check(cal_start, 24'h0);
    commit();
    check(cal_start, 24'h0);
    cal_set(1'b0);
    commit();
    cal_set(1'b1);
    commit();
    check({cal_active, cal_start}, 24'h3);
    // save, reset and restore
    cfg(6'h3F, 2'h0, 1, 1, 0, 3'h4, 3'h2);
    commit();
    check(chan_mhz <= MAX_CHAN_MHZ, 24'h1);
    nv_save = 1'b1;
    @(negedge mclk) nv_save = 1'b0;
    reset_n = 1'b0;
    @(negedge mclk);
    check_cfg(2'h1, 0, 0, 0, 3'h0, 3'h0);
    reset_n = 1'b1;
    wait_ready();
    check_cfg(2'h0, 1, 1, 0, 3'h4, 3'h2);
    give_verdict();
  end
endmodule

// ---- sim/cpm_src_model.sv ----
// behavioural model of the clock source and vco on the far side of the path
`timescale 1ns/10ps
module cpm_src_model #(
  parameter int EXT_MHZ = 2400,
  parameter int VCO_MHZ = 2400
) (
  input wire logic src_vco,
  input wire logic [2:0] div_ratio,
  output int chan_mhz
);
  // frequency handed to the channel dividers after the vco divider
  assign chan_mhz = (src_vco ? VCO_MHZ : EXT_MHZ) / ((div_ratio == 3'h0) ? 1 : int'(div_ratio));
endmodule
